// ### src/dul_buf.sv
`timescale 1ns/100ps
module dul_buf (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_in_valid,
	input  wire logic [dul_pkg::DATA_W-1:0] i_in_data,
	output logic                           o_in_ready,
	output logic                           o_out_valid,
	output logic      [dul_pkg::DATA_W-1:0] o_out_data,
	input  wire logic                      i_out_ready
);
	import dul_pkg::*;

	typedef struct packed {
		dul_word_type [BUF_DEPTH-1:0] slot;
		logic                         wr_idx;
		logic                         rd_idx;
	} dul_buf_state_type;

	dul_buf_state_type state_ff;
	dul_buf_state_type nxt_state;
	logic              push;
	logic              pop;

	assign o_in_ready  = !state_ff.slot[state_ff.wr_idx].valid;
	assign o_out_valid = state_ff.slot[state_ff.rd_idx].valid;
	assign o_out_data  = state_ff.slot[state_ff.rd_idx].data;
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		nxt_state = state_ff;
		if (pop) begin
			nxt_state.slot[state_ff.rd_idx].valid = 1'b0;
			nxt_state.rd_idx = !state_ff.rd_idx;
		end
		if (push) begin
			nxt_state.slot[state_ff.wr_idx].valid = 1'b1;
			nxt_state.slot[state_ff.wr_idx].data  = i_in_data;
			nxt_state.wr_idx = !state_ff.wr_idx;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule : dul_buf

// ### src/dul_pkg.sv
package dul_pkg;

	localparam int unsigned NUM_CH          = 2;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned MCR_IR_BIT      = 6;
	localparam int unsigned FEATURE_CONTROL_REG_RXPOL_BIT  = 4;
	localparam logic        TX_IDLE_NORMAL  = 1'b1;
	localparam logic        TX_IDLE_IR      = 1'b0;
	localparam logic        RX_IDLE_NORMAL  = 1'b1;
	localparam logic        RX_IDLE_IR      = 1'b0;
	localparam logic        MODEM_OUT_RST   = 1'b1;
	localparam logic [7:0]  MCR_RST         = 8'h00;
	localparam logic [7:0]  FEATURE_CONTROL_REG_RST        = 8'h00;
	localparam logic [3:0]  BAUD_DIV_RST    = 4'hf;
	localparam logic [3:0]  BIT_CNT_LAST    = 4'h9;
	localparam logic [3:0]  SAMPLE_HALF     = 4'h7;
	localparam logic [3:0]  SAMPLE_LAST     = 4'hf;
	localparam int unsigned BUF_DEPTH       = 2;

	typedef struct packed {
		logic rts_n;
		logic dtr_n;
	} dul_modem_out_type;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic cd_n;
		logic ri_n;
	} dul_modem_in_type;

	typedef struct packed {
		logic       valid;
		logic [DATA_W-1:0] data;
	} dul_word_type;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} dul_tx_state_type;

endpackage : dul_pkg

// ### src/dul_sync.sv
`timescale 1ns/100ps
module dul_sync (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_rst_val,
	input  wire logic [4:0] i_async,
	output logic      [4:0] o_sync
);
	import dul_pkg::*;

	typedef struct packed {
		logic [4:0] stage1;
		logic [4:0] stage2;
	} dul_sync_state_type;

	dul_sync_state_type state_ff;
	dul_sync_state_type nxt_state;

	always_comb begin
		nxt_state        = state_ff;
		nxt_state.stage1 = i_async;
		nxt_state.stage2 = state_ff.stage1;
	end

	// reset to idle-high pin level, constant
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= '1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign o_sync = state_ff.stage2;

	logic unused_rst_val;
	assign unused_rst_val = i_rst_val;

endmodule : dul_sync

// ### src/dul_top.sv
// Functional notes
// - in normal mode each transmit line rests high whenever no character is sent.
// - in infrared mode each transmit line rests low while idle so no pulses go out.
// - in infrared mode feature bit 4 clear makes a low receive level mark, set makes it space.
// - each channel drives an active-low send request output usable as a plain output.
// - each channel drives an active-low terminal ready output usable as a plain output.
// - each channel samples an active-low clear-to-send input, also readable as plain input.
// - each channel samples an active-low set-ready input, also readable as plain input.
// - each channel samples an active-low carrier detect input, also readable as plain input.
// - each channel samples an active-low ring input, also readable as plain input.
// - two independent identical channels 0 and 1 each have full pin sets.
// - the infrared strap is sampled at reset release and sets modem control bit 6 in both.
`timescale 1ns/100ps
module dul_top (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_infrared_strap_pin,
	input  wire logic [1:0]                 i_ir_mode_wr,
	input  wire logic [1:0]                 i_ir_mode_val,
	input  wire logic [1:0]                 i_rx_pol_invert,
	input  wire logic [1:0]                 i_send_request_on,
	input  wire logic [1:0]                 i_terminal_ready_on,
	input  wire logic [1:0]                 i_tx_valid,
	input  wire logic [dul_pkg::DATA_W-1:0] i_tx_data_ch0,
	input  wire logic [dul_pkg::DATA_W-1:0] i_tx_data_ch1,
	output logic      [1:0]                 o_tx_ready,
	input  wire logic                       i_serial_in_ch0,
	input  wire logic                       i_serial_in_ch1,
	input  wire logic                       i_clear_to_send_n_ch0,
	input  wire logic                       i_clear_to_send_n_ch1,
	input  wire logic                       i_set_ready_n_ch0,
	input  wire logic                       i_set_ready_n_ch1,
	input  wire logic                       i_carrier_detect_n_ch0,
	input  wire logic                       i_carrier_detect_n_ch1,
	input  wire logic                       i_ring_indicator_n_ch0,
	input  wire logic                       i_ring_indicator_n_ch1,
	output logic                            o_serial_out_ch0,
	output logic                            o_serial_out_ch1,
	output logic                            o_send_request_n_ch0,
	output logic                            o_send_request_n_ch1,
	output logic                            o_terminal_ready_n_ch0,
	output logic                            o_terminal_ready_n_ch1,
	output logic      [1:0]                 o_ir_mode,
	output logic      [1:0]                 o_rx_mark,
	output logic      [1:0]                 o_clear_to_send,
	output logic      [1:0]                 o_set_ready,
	output logic      [1:0]                 o_carrier_detect,
	output logic      [1:0]                 o_ring_indicator,
	output logic      [3:0]                 o_gpin_ch0,
	output logic      [3:0]                 o_gpin_ch1
);
	import dul_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// per-channel state

	typedef struct packed {
		logic [7:0]        modem_ctrl_reg;
		logic [7:0]        feature_control_reg;
		dul_tx_state_type  tx_state;
		logic [3:0]        baud_cnt;
		logic [3:0]        bit_cnt;
		logic [DATA_W-1:0] shift;
		logic              tx_line;
		dul_modem_out_type mout;
		dul_modem_in_type  min;
		logic              rx_mark;
	} dul_ch_type;

	typedef struct packed {
		logic                    strap_pending;
		dul_ch_type [NUM_CH-1:0] ch;
	} dul_state_type;

	dul_state_type state_ff;
	dul_state_type nxt_state;

	logic [NUM_CH-1:0][4:0]        pin_raw;
	logic [NUM_CH-1:0][4:0]        pin_sync;
	logic [NUM_CH-1:0][DATA_W-1:0] tx_data_in;
	logic [NUM_CH-1:0][DATA_W-1:0] buf_data;
	logic [NUM_CH-1:0]             buf_valid;
	logic [NUM_CH-1:0]             buf_take;

	assign tx_data_in[0] = i_tx_data_ch0;
	assign tx_data_in[1] = i_tx_data_ch1;
	assign pin_raw[0] = {i_serial_in_ch0, i_clear_to_send_n_ch0, i_set_ready_n_ch0,
		i_carrier_detect_n_ch0, i_ring_indicator_n_ch0};
	assign pin_raw[1] = {i_serial_in_ch1, i_clear_to_send_n_ch1, i_set_ready_n_ch1,
		i_carrier_detect_n_ch1, i_ring_indicator_n_ch1};

	////////////////////////////////////////////////////////////////////////
	// synchronisers and transmit buffers

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			dul_sync u_sync (
				.i_ref_clk (i_ref_clk),
				.i_rst     (i_rst),
				.i_rst_val (1'b1),
				.i_async   (pin_raw[c]),
				.o_sync    (pin_sync[c])
			);
			dul_buf u_buf (
				.i_ref_clk   (i_ref_clk),
				.i_rst       (i_rst),
				.i_in_valid  (i_tx_valid[c]),
				.i_in_data   (tx_data_in[c]),
				.o_in_ready  (o_tx_ready[c]),
				.o_out_valid (buf_valid[c]),
				.o_out_data  (buf_data[c]),
				.i_out_ready (buf_take[c])
			);
		end
	endgenerate

	function automatic logic idle_level(input logic ir);
		idle_level = ir ? TX_IDLE_IR : TX_IDLE_NORMAL;
	endfunction : idle_level

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic ir;
		logic data_bit;
		logic rx_lvl;
		ir        = 1'b0;
		data_bit  = 1'b0;
		rx_lvl    = 1'b0;
		nxt_state = state_ff;
		buf_take  = '0;
		nxt_state.strap_pending = 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			if (state_ff.strap_pending) begin
				nxt_state.ch[c].modem_ctrl_reg[MCR_IR_BIT] = i_infrared_strap_pin;
			end else if (i_ir_mode_wr[c]) begin
				nxt_state.ch[c].modem_ctrl_reg[MCR_IR_BIT] = i_ir_mode_val[c];
			end
			nxt_state.ch[c].feature_control_reg[FEATURE_CONTROL_REG_RXPOL_BIT] = i_rx_pol_invert[c];
			ir = state_ff.ch[c].modem_ctrl_reg[MCR_IR_BIT];

			nxt_state.ch[c].mout.rts_n = !i_send_request_on[c];
			nxt_state.ch[c].mout.dtr_n = !i_terminal_ready_on[c];
			nxt_state.ch[c].min = {pin_sync[c][3], pin_sync[c][2],
				pin_sync[c][1], pin_sync[c][0]};

			rx_lvl = pin_sync[c][4];
			if (ir) begin
				// polarity bit clear: low is mark
				nxt_state.ch[c].rx_mark = state_ff.ch[c].feature_control_reg[FEATURE_CONTROL_REG_RXPOL_BIT]
					? rx_lvl : !rx_lvl;
			end else begin
				nxt_state.ch[c].rx_mark = rx_lvl;
			end

			// infrared: a one bit leaves the line at its resting low
			nxt_state.ch[c].baud_cnt = state_ff.ch[c].baud_cnt - 4'h1;
			unique case (state_ff.ch[c].tx_state)
				TX_IDLE: begin
					nxt_state.ch[c].tx_line = idle_level(ir);
					if (buf_valid[c]) begin
						buf_take[c] = 1'b1;
						nxt_state.ch[c].shift    = buf_data[c];
						nxt_state.ch[c].baud_cnt = BAUD_DIV_RST;
						nxt_state.ch[c].tx_state = TX_START;
					end
				end
				TX_START: begin
					nxt_state.ch[c].tx_line = ir ? (state_ff.ch[c].baud_cnt > SAMPLE_HALF)
						: 1'b0;
					if (state_ff.ch[c].baud_cnt == 4'h0) begin
						nxt_state.ch[c].bit_cnt  = 4'h0;
						nxt_state.ch[c].tx_state = TX_DATA;
					end
				end
				TX_DATA: begin
					data_bit = state_ff.ch[c].shift[0];
					nxt_state.ch[c].tx_line = ir ?
						(!data_bit && state_ff.ch[c].baud_cnt > SAMPLE_HALF) : data_bit;
					if (state_ff.ch[c].baud_cnt == 4'h0) begin
						nxt_state.ch[c].shift   = state_ff.ch[c].shift >> 1;
						nxt_state.ch[c].bit_cnt = state_ff.ch[c].bit_cnt + 4'h1;
						if (state_ff.ch[c].bit_cnt == 4'(DATA_W - 1)) begin
							nxt_state.ch[c].tx_state = TX_STOP;
						end
					end
				end
				TX_STOP: begin
					nxt_state.ch[c].tx_line = idle_level(ir);
					if (state_ff.ch[c].baud_cnt == 4'h0) begin
						nxt_state.ch[c].tx_state = TX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= '0;
			state_ff.strap_pending <= 1'b1;
			for (int c = 0; c < NUM_CH; c++) begin
				state_ff.ch[c].modem_ctrl_reg      <= MCR_RST;
				state_ff.ch[c].feature_control_reg <= FEATURE_CONTROL_REG_RST;
				state_ff.ch[c].tx_state            <= TX_IDLE;
				state_ff.ch[c].tx_line             <= TX_IDLE_NORMAL;
				state_ff.ch[c].mout                <= '1;
				state_ff.ch[c].min                 <= '1;
				state_ff.ch[c].rx_mark             <= 1'b1;
			end
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign o_serial_out_ch0       = state_ff.ch[0].tx_line;
	assign o_serial_out_ch1       = state_ff.ch[1].tx_line;
	assign o_send_request_n_ch0   = state_ff.ch[0].mout.rts_n;
	assign o_send_request_n_ch1   = state_ff.ch[1].mout.rts_n;
	assign o_terminal_ready_n_ch0 = state_ff.ch[0].mout.dtr_n;
	assign o_terminal_ready_n_ch1 = state_ff.ch[1].mout.dtr_n;
	assign o_gpin_ch0             = state_ff.ch[0].min;
	assign o_gpin_ch1             = state_ff.ch[1].min;

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_out
			assign o_ir_mode[c]        = state_ff.ch[c].modem_ctrl_reg[MCR_IR_BIT];
			assign o_rx_mark[c]        = state_ff.ch[c].rx_mark;
			assign o_clear_to_send[c]  = !state_ff.ch[c].min.cts_n;
			assign o_set_ready[c]      = !state_ff.ch[c].min.dsr_n;
			assign o_carrier_detect[c] = !state_ff.ch[c].min.cd_n;
			assign o_ring_indicator[c] = !state_ff.ch[c].min.ri_n;
		end
	endgenerate

endmodule : dul_top

// ### test/dul_remote.sv
`timescale 1ns/100ps
module dul_remote (
	input  wire logic [1:0] i_ir_mode,
	input  wire logic [1:0] i_rx_busy,
	input  wire logic [1:0] i_rx_level,
	output logic      [1:0] o_serial_in
);
	// idle level follows the mode; driven level only while busy
	assign o_serial_in = (i_rx_busy & i_rx_level) | (~i_rx_busy & ~i_ir_mode);
endmodule : dul_remote

// ### test/dul_top_assertions.sv
`timescale 1ns/100ps
module dul_top_chk (
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_infrared_strap_pin,
	input wire logic [1:0] i_ir_mode_wr,
	input wire logic [1:0] i_ir_mode_val,
	input wire logic [1:0] i_rx_pol_invert,
	input wire logic [1:0] i_send_request_on,
	input wire logic [1:0] i_terminal_ready_on,
	input wire logic [1:0] i_tx_valid,
	input wire logic [1:0] o_tx_ready,
	input wire logic       i_serial_in_ch0,
	input wire logic       i_clear_to_send_n_ch0,
	input wire logic       i_ring_indicator_n_ch1,
	input wire logic       o_serial_out_ch0,
	input wire logic       o_send_request_n_ch0,
	input wire logic       o_terminal_ready_n_ch1,
	input wire logic [1:0] o_ir_mode,
	input wire logic [1:0] o_rx_mark,
	input wire logic [1:0] o_clear_to_send,
	input wire logic [3:0] o_gpin_ch1
);
	logic [9:0] quiet_ff;
	// cycles since the last byte taken on channel 0, saturating
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) quiet_ff <= 10'h000;
		else if (i_tx_valid[0] && o_tx_ready[0]) quiet_ff <= 10'h000;
		else if (quiet_ff != 10'h3ff) quiet_ff <= quiet_ff + 10'h001;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	chk_tx_idle_norm: assert property (
		quiet_ff >= 10'd500 && !o_ir_mode[0] && $stable(o_ir_mode[0]) |-> o_serial_out_ch0)
		else $error("idle line not high in normal mode");
	chk_tx_idle_ir: assert property (
		quiet_ff >= 10'd500 && o_ir_mode[0] && $stable(o_ir_mode[0]) |-> !o_serial_out_ch0)
		else $error("idle line not low in infrared mode");
	chk_rts_drive: assert property (i_send_request_on[0] |=> !o_send_request_n_ch0)
		else $error("send request not driven low");
	chk_dtr_release: assert property (!i_terminal_ready_on[1] |=> o_terminal_ready_n_ch1)
		else $error("terminal ready not released");
	chk_cts_sync: assert property (
		o_clear_to_send[0] == !$past(i_clear_to_send_n_ch0, 3))
		else $error("clear to send status wrong");
	chk_ri_raw: assert property (o_gpin_ch1[0] == $past(i_ring_indicator_n_ch1, 3))
		else $error("raw ring pin level wrong");
	chk_rx_polarity: assert property (
		o_ir_mode[0] && $past(o_ir_mode[0]) && $past(o_ir_mode[0], 3)
		&& $stable(i_rx_pol_invert[0])
		&& $past(i_rx_pol_invert[0]) == $past(i_rx_pol_invert[0], 3)
		|-> o_rx_mark[0] == ($past(i_serial_in_ch0, 3) == i_rx_pol_invert[0]))
		else $error("infrared receive polarity wrong");
	chk_strap_load: assert property (
		$past(i_rst) |=> o_ir_mode == {2{$past(i_infrared_strap_pin)}})
		else $error("strap not loaded into mode");
	chk_ir_write: assert property (
		i_ir_mode_wr[1] && !$past(i_rst) |=> o_ir_mode[1] == $past(i_ir_mode_val[1]))
		else $error("mode write not taken");
endmodule : dul_top_chk
bind dul_top dul_top_chk i_chk (.*);

// ### test/tb_dual_uart_line_pins.sv
`timescale 1ns/100ps
module tb_dual_uart_line_pins;
	logic       i_ref_clk, i_rst, i_infrared_strap_pin, i_serial_in_ch0, i_serial_in_ch1;
	logic       i_clear_to_send_n_ch0, i_clear_to_send_n_ch1, i_set_ready_n_ch0, i_set_ready_n_ch1;
	logic       i_carrier_detect_n_ch0, i_carrier_detect_n_ch1;
	logic       i_ring_indicator_n_ch0, i_ring_indicator_n_ch1;
	logic       o_serial_out_ch0, o_serial_out_ch1, o_send_request_n_ch0, o_send_request_n_ch1;
	logic       o_terminal_ready_n_ch0, o_terminal_ready_n_ch1;
	logic [1:0] i_ir_mode_wr, i_ir_mode_val, i_rx_pol_invert, i_send_request_on;
	logic [1:0] i_terminal_ready_on, i_tx_valid, o_tx_ready, o_ir_mode, o_rx_mark;
	logic [1:0] o_clear_to_send, o_set_ready, o_carrier_detect, o_ring_indicator, rx_busy, rx_level;
	logic [3:0] o_gpin_ch0, o_gpin_ch1;
	logic [7:0] i_tx_data_ch0, i_tx_data_ch1, modem_n;
	int         fail_count, compares, takes;
	logic [23:0] rows [4] = '{24'hf_00_0_ff, 24'h5_0f_a_aa, 24'ha_5a_5_99, 24'h0_ff_f_00};
	assign {i_clear_to_send_n_ch1, i_set_ready_n_ch1, i_carrier_detect_n_ch1, i_ring_indicator_n_ch1,
		i_clear_to_send_n_ch0, i_set_ready_n_ch0, i_carrier_detect_n_ch0, i_ring_indicator_n_ch0} = modem_n;
	dul_top i_dut (.*);
	dul_remote i_remote (.i_ir_mode(o_ir_mode), .i_rx_busy(rx_busy), .i_rx_level(rx_level),
		.o_serial_in({i_serial_in_ch1, i_serial_in_ch0}));
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic reset_dut(input logic strap);
		i_rst = 1'b1;
		i_infrared_strap_pin = strap;
		repeat (8) @(negedge i_ref_clk);
		check("reset outputs", {o_serial_out_ch1, o_serial_out_ch0, o_send_request_n_ch1,
			o_send_request_n_ch0, o_terminal_ready_n_ch1, o_terminal_ready_n_ch0, o_tx_ready}, 8'hff);
		check("reset mode", {o_ir_mode, o_rx_mark}, 4'h3);
		i_rst = 1'b0;
		@(negedge i_ref_clk);
		i_infrared_strap_pin = ~strap;
		@(negedge i_ref_clk);
		check("strap mode", o_ir_mode, {2{strap}});
		$display("reset done");
	endtask : reset_dut
	// line sampled a few cycles into each bit, inside the infrared pulse
	task automatic frame(input int ch, input logic [7:0] b);
		logic [9:0] bits;
		logic       ir;
		bits = {1'b1, b, 1'b0};
		ir = o_ir_mode[ch];
		if (ch == 0) i_tx_data_ch0 = b;
		else i_tx_data_ch1 = b;
		i_tx_valid[ch] = 1'b1;
		@(negedge i_ref_clk);
		i_tx_valid[ch] = 1'b0;
		repeat (5) @(negedge i_ref_clk);
		for (int k = 0; k < 10; k++) begin
			check("tx bit", ch ? o_serial_out_ch1 : o_serial_out_ch0, bits[k] != ir);
			repeat (16) @(negedge i_ref_clk);
		end
		check("tx idle", ch ? o_serial_out_ch1 : o_serial_out_ch0, !ir);
		$display("frame done");
	endtask : frame
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		fail_count++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		i_rst = 1'b1;
		{i_ir_mode_wr, i_ir_mode_val, i_rx_pol_invert, i_send_request_on} = 8'h00;
		{i_terminal_ready_on, i_tx_valid, rx_busy, rx_level} = 8'h00;
		{i_tx_data_ch0, i_tx_data_ch1} = 16'h0000;
		modem_n = 8'hff;
		reset_dut(1'b0);
		foreach (rows[i]) begin
			{i_send_request_on, i_terminal_ready_on, modem_n} = rows[i][23:12];
			repeat (4) @(negedge i_ref_clk);
			check("modem out", {o_send_request_n_ch1, o_send_request_n_ch0, o_terminal_ready_n_ch1,
				o_terminal_ready_n_ch0}, rows[i][11:8]);
			check("status", {o_clear_to_send, o_set_ready, o_carrier_detect, o_ring_indicator},
				rows[i][7:0]);
			check("raw pins", {o_gpin_ch1, o_gpin_ch0}, modem_n);
		end
		$display("table done");
		frame(0, 8'ha5);
		{i_ir_mode_wr[1], i_ir_mode_val[1]} = 2'b11;
		@(negedge i_ref_clk);
		i_ir_mode_wr[1] = 1'b0;
		frame(1, 8'h96);
		check("rx mark normal", o_rx_mark[0], 1'b1);
		for (int q = 0; q < 4; q++) begin
			i_rx_pol_invert[1] = q[1];
			{rx_busy[1], rx_level[1]} = {q[0], 1'b1};
			repeat (5) @(negedge i_ref_clk);
			check("rx mark", o_rx_mark[1], q[0] == q[1]);
		end
		rx_busy = 2'b00;
		$display("polarity done");
		i_tx_valid[0] = 1'b1;
		takes = 0;
		repeat (6) begin
			if (o_tx_ready[0] === 1'b1) takes++;
			@(negedge i_ref_clk);
		end
		check("takes", takes[7:0], 8'h03);
		check("refused", o_tx_ready[0], 1'b0);
		i_tx_valid[0] = 1'b0;
		repeat (520) @(negedge i_ref_clk);
		check("drained", o_tx_ready[0], 1'b1);
		$display("buffer done");
		reset_dut(1'b1);
		repeat (520) @(negedge i_ref_clk);
		check("ir idle", o_serial_out_ch0, 1'b0);
		frame(0, 8'h3c);
		conclude();
	end
endmodule : tb_dual_uart_line_pins
